// [idesq_pkg.sv]
package idesq_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned T_START_US    = 250;
  localparam int unsigned T_REFRESH_US  = 12;
  // each time rounds down, never below one cycle
  localparam int unsigned START_CYC_RAW = (T_START_US * (CLK_HZ / 1_000_000));
  localparam int unsigned START_CYC     = (START_CYC_RAW < 1) ? 1 : START_CYC_RAW;
  localparam int unsigned REFR_CYC_RAW  = (T_REFRESH_US * (CLK_HZ / 1_000_000));
  localparam int unsigned REFR_CYC      = (REFR_CYC_RAW < 1) ? 1 : REFR_CYC_RAW;
  localparam int unsigned TMR_W         = 16;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 16'h0001;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDESQ_OFF, IDESQ_START, IDESQ_RUN} idesq_mode_t;

  typedef struct packed {
    logic primary_ok;   // primary_supply above its undervoltage level
    logic rail_ok;      // isolated_bias_rail above secondary threshold
    logic stable;       // internal voltages settled
  } idesq_status_t;

  typedef struct packed {
    logic        gate_hi;
    logic        gate_pulldown_output;
    logic        en_oe;
    logic        en_o;
    logic        xfer_en;
    logic        refresh;
    logic        ready;
  } idesq_out_t;
endpackage

// [idesq_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser; first stage feeds only the second
module idesq_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } idesq_sync_st_t;

  idesq_sync_st_t st;
  idesq_sync_st_t next_st;

  // ---------------------------------------------------------------
  // stages
  // ---------------------------------------------------------------
  always_comb begin
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.s2;
endmodule

// [idesq_top.sv]
`timescale 1ns/1ps
module idesq_top #(
  parameter int unsigned START_CYCLES = idesq_pkg::START_CYC
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_pwm,
  input  wire logic                    i_en,
  input  wire idesq_pkg::idesq_status_t i_status,
  output logic                         o_en_o,
  output logic                         o_en_oe,
  output logic                         o_gate_hi,
  output logic                         o_gate_pulldown_output,
  output logic                         o_xfer_en,
  output logic                         o_refresh,
  output logic                         o_ready
);
  import idesq_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [4:0]    sync_q;
  logic          pwm_s;
  logic          en_s;
  idesq_status_t st_s;

  // pins from outside the clock domain pass two flops first
  // costs two cycles on every pin, traded for metastability margin
  idesq_sync #(.W(5)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_pwm, i_en, i_status}),
    .o_q   (sync_q)
  );

  assign pwm_s = sync_q[4];
  assign en_s  = sync_q[3];
  assign st_s  = sync_q[2:0];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    idesq_mode_t      mode;
    logic [TMR_W-1:0] start_tmr;
    logic [TMR_W-1:0] refr_tmr;
    logic             pwm_last;
    idesq_out_t       out;
  } idesq_st_t;

  idesq_st_t st;
  idesq_st_t next_st;

  localparam logic [TMR_W-1:0] START_LOAD = TMR_W'(START_CYCLES);
  localparam logic [TMR_W-1:0] REFR_LOAD  = TMR_W'(REFR_CYC);

  // ---------------------------------------------------------------
  // sequencing and output path
  // ---------------------------------------------------------------
  always_comb begin
    logic pull;
    logic gate_ok;
    pull    = 1'b0;
    gate_ok = 1'b0;
    next_st = st;
    next_st.out.refresh = 1'b0;
    next_st.pwm_last    = pwm_s;
    case (st.mode)
      IDESQ_OFF: begin
        // supply up: arm the startup timer
        if (st_s.primary_ok) begin
          next_st.mode      = IDESQ_START;
          next_st.start_tmr = START_LOAD;
        end
      end
      IDESQ_START: begin
        if (!st_s.primary_ok) begin
          next_st.mode = IDESQ_OFF;
        end else if (st.start_tmr != TMR_ZERO) begin
          next_st.start_tmr = st.start_tmr - TMR_ONE;
        end else if (st_s.stable) begin
          next_st.mode = IDESQ_RUN;
        end
      end
      IDESQ_RUN: begin
        if (!st_s.primary_ok) begin
          next_st.mode = IDESQ_OFF;
        end else if (!st_s.stable) begin
          next_st.mode      = IDESQ_START;
          next_st.start_tmr = TMR_ZERO;
        end
      end
      default: begin
        next_st.mode = IDESQ_OFF;
      end
    endcase
    // pull-down while off or starting, released only in run
    pull = (next_st.mode != IDESQ_RUN);
    // gate follows pwm only with line high, run, and rail up
    gate_ok = en_s && (st.mode == IDESQ_RUN) && st_s.primary_ok && st_s.rail_ok;
    next_st.out.gate_hi              = gate_ok && pwm_s;
    next_st.out.gate_pulldown_output = !(gate_ok && pwm_s);
    // output value is always low; only the enable toggles
    next_st.out.en_o  = 1'b0;
    next_st.out.en_oe = pull;
    // standby drops energy transfer; line low means a party holds it
    next_st.out.xfer_en = en_s && st_s.primary_ok;
    next_st.out.ready   = en_s && (st.mode == IDESQ_RUN);
    // refresh timer restarts on any pwm change and is held loaded while not transferring
    if (!next_st.out.xfer_en || (pwm_s != st.pwm_last)) begin
      next_st.refr_tmr = REFR_LOAD;
    end else if (st.refr_tmr <= TMR_ONE) begin
      next_st.refr_tmr    = REFR_LOAD;
      next_st.out.refresh = 1'b1;
    end else begin
      next_st.refr_tmr = st.refr_tmr - TMR_ONE;
    end
  end

  // reset keeps the line pulled and the gate held low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st                          <= '0;
      st.mode                     <= IDESQ_OFF;
      st.refr_tmr                 <= REFR_LOAD;
      st.out.gate_pulldown_output <= 1'b1;
      st.out.en_oe                <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  assign o_en_o                 = st.out.en_o;
  assign o_en_oe                = st.out.en_oe;
  assign o_gate_hi              = st.out.gate_hi;
  assign o_gate_pulldown_output = st.out.gate_pulldown_output;
  assign o_xfer_en              = st.out.xfer_en;
  assign o_refresh              = st.out.refresh;
  assign o_ready                = st.out.ready;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // delayed copies of synced pins, read by the covers only
  logic [2:0] sync_d1;
  logic [2:0] sync_d2;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_d1 <= '0;
      sync_d2 <= '0;
    end else begin
      sync_d1 <= {en_s, st_s.primary_ok, pwm_s};
      sync_d2 <= sync_d1;
    end
  end

  chk_line_low_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !en_s |=> !o_gate_hi && o_gate_pulldown_output) else $error("gate high while enable low");
  chk_pass_through: assert property (@(posedge i_clk) disable iff (i_rst)
    (en_s && st.mode == IDESQ_RUN && st_s.primary_ok && st_s.rail_ok) |=> (o_gate_hi == $past(pwm_s)))
    else $error("pwm not passed through");
  chk_start_pull: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.mode == IDESQ_START) |-> o_en_oe) else $error("line released during startup");
  chk_never_high: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_en_o) else $error("enable driven high");
  chk_standby_xfer: assert property (@(posedge i_clk) disable iff (i_rst)
    !en_s |=> !o_xfer_en) else $error("transfer during standby");
  chk_rail_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_s.rail_ok |=> !o_gate_hi) else $error("gate high without rail");
  chk_timer_runs: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.mode == IDESQ_OFF && st_s.primary_ok) |=> (st.mode == IDESQ_START && st.start_tmr == START_LOAD))
    else $error("startup timer not armed");
  chk_release_cond: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_en_oe) |-> ($past(st.start_tmr) == TMR_ZERO) && $past(st_s.primary_ok) && $past(st_s.stable))
    else $error("line released early");
  chk_uv_shutdown: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_s.primary_ok |=> o_en_oe && o_gate_pulldown_output) else $error("no shutdown on undervoltage");
  chk_refresh_static: assert property (@(posedge i_clk) disable iff (i_rst)
    o_refresh |-> $past(pwm_s) == $past(pwm_s, 2)) else $error("refresh on pwm change");

  // ---------------------------------------------------------------
  // output stage, standby and startup timer checks
  // ---------------------------------------------------------------
  // gate pull-up and pull-down never fight, never both float
  chk_gate_excl: assert property (@(posedge i_clk) disable iff (i_rst)
    o_gate_hi != o_gate_pulldown_output) else $error("gate drivers not complementary");
  // supply loss holds the gate low on the next edge
  chk_uv_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_s.primary_ok |=> !o_gate_hi && o_gate_pulldown_output)
    else $error("gate not held low on undervoltage");
  // no refresh transfer may leak out while the line is low
  chk_standby_ref: assert property (@(posedge i_clk) disable iff (i_rst)
    !en_s |=> !o_refresh) else $error("refresh during standby");
  // an armed startup timer is never skipped
  chk_start_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.mode == IDESQ_START && st.start_tmr != TMR_ZERO) |=> (st.mode != IDESQ_RUN))
    else $error("startup timer skipped");

  // main scenarios reached at least once

  cov_startup: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_en_oe));
  cov_gate_on: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_gate_hi));
  cov_refresh: cover property (@(posedge i_clk) disable iff (i_rst) o_refresh);
  cov_uv_drop: cover property (@(posedge i_clk) disable iff (i_rst) sync_d1[1] && !st_s.primary_ok);
  cov_ext_low: cover property (@(posedge i_clk) disable iff (i_rst) !o_en_oe && sync_d2[2] && !en_s);
endmodule

// [idesq_ctrl_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// pwm controller on the far side of the shared enable wire
// ---------------------------------------------------------------
module idesq_ctrl_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pull_cmd,
  input  wire logic i_pwm_cmd,
  input  wire logic i_primary_ok,
  output logic      o_pull,
  output logic      o_pwm
);
  // pulls the wire during its own reset so the line never floats
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pull <= 1'b1;
      o_pwm  <= 1'b0;
    end else begin
      o_pull <= i_pull_cmd;
      o_pwm  <= i_pwm_cmd & i_primary_ok;
    end
  end
endmodule

// [tb_isolated_driver_enable_sequencer.sv]
`timescale 1ns/1ps
module tb_isolated_driver_enable_sequencer;
  import idesq_pkg::*;
  localparam int unsigned START_SIM = 20;
  logic          i_clk    = 1'b0;
  logic          i_rst    = 1'b1;
  logic          pull_cmd = 1'b1;
  logic          pwm_cmd  = 1'b0;
  idesq_status_t status   = 3'h0;
  logic          ctrl_pull, ctrl_pwm, line, en_o, en_oe, gate_hi, gate_pd, xfer_en, refresh, ready;
  int            n_errors    = 0;
  int            checks_done = 0;
  int            n;
  logic          leak;

  always #25 i_clk = ~i_clk;
  // wired-and wire: pull-up unless some party sinks it
  assign line = ~(en_oe | ctrl_pull);

  idesq_ctrl_model u_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_pull_cmd(pull_cmd), .i_pwm_cmd(pwm_cmd),
    .i_primary_ok(status.primary_ok), .o_pull(ctrl_pull), .o_pwm(ctrl_pwm));
  idesq_top #(.START_CYCLES(START_SIM)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_pwm(ctrl_pwm),
    .i_en(line), .i_status(status), .o_en_o(en_o), .o_en_oe(en_oe), .o_gate_hi(gate_hi),
    .o_gate_pulldown_output(gate_pd), .o_xfer_en(xfer_en), .o_refresh(refresh), .o_ready(ready));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic drv(input logic pull, input logic pwm, input logic [2:0] st);
    @(posedge i_clk);
    pull_cmd <= pull;
    pwm_cmd  <= pwm;
    status   <= st;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // pwm toggled early on purpose; controller holds the wire low too
  task automatic t_startup();
    check(en_oe, 1'b1);
    drv(1'b1, 1'b1, 3'h7);
    leak = 1'b0;
    for (n = 0; n < 200 && en_oe !== 1'b0; n++) begin
      cyc(1);
      leak = leak | gate_hi;
    end
    if (n >= 200) begin
      n_errors++;
      $display("startup timed out");
    end
    check(leak, 1'b0);
    check(n >= START_SIM, 1'b1);
    cyc(4);
    check(line, 1'b0);
    check(gate_hi, 1'b0);
    check(en_o, 1'b0);
    drv(1'b0, 1'b1, 3'h7);
    cyc(6);
    check(gate_hi, 1'b1);
    check(gate_pd, 1'b0);
    check(ready, 1'b1);
    $display("startup done");
  endtask
  // external disable with pwm high, then re-enable with a low rail
  task automatic t_ext_disable();
    drv(1'b1, 1'b1, 3'h7);
    cyc(6);
    check(gate_hi, 1'b0);
    check(gate_pd, 1'b1);
    check(xfer_en, 1'b0);
    check(en_oe, 1'b0);
    drv(1'b0, 1'b1, 3'h5);
    cyc(6);
    check(xfer_en, 1'b1);
    check(gate_hi, 1'b0);
    drv(1'b0, 1'b1, 3'h7);
    cyc(6);
    check(gate_hi, 1'b1);
    $display("ext disable done");
  endtask
  // static pwm: spacing between two refresh pulses
  task automatic t_refresh();
    drv(1'b0, 1'b0, 3'h7);
    for (n = 0; n < 300 && refresh !== 1'b1; n++) cyc(1);
    if (n >= 300) begin
      n_errors++;
      $display("refresh timed out");
    end
    for (n = 1; n < 300; n++) begin
      cyc(1);
      if (refresh === 1'b1) break;
    end
    check(n, REFR_CYC);
    $display("refresh done");
  endtask
  // primary supply lost while running
  task automatic t_uv();
    drv(1'b0, 1'b1, 3'h3);
    cyc(6);
    check(en_oe, 1'b1);
    check(line, 1'b0);
    check(gate_pd, 1'b1);
    check(gate_hi, 1'b0);
    $display("undervoltage done");
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    cyc(2);
    t_startup();
    t_ext_disable();
    t_refresh();
    t_uv();
    print_verdict();
  end
endmodule
